// ### common/sph_pkg.sv
// constants shared by the serial port handshake block
package sph_pkg;
   // one bit time in core_clk cycles; no baud selection in this block
   localparam logic [7:0] SPH_BIT_CYCLES = 8'h10;
   // half a bit, used by the receiver to land in mid-bit
   localparam logic [7:0] SPH_HALF_CYCLES = 8'h08;
   // highest data bit index (bits 1..8 travel as index 0..7)
   localparam logic [2:0] SPH_LAST_BIT = 3'h7;
   // flow control codes, each with its top bit as sent on the line
   localparam logic [7:0] SPH_START_CODE = 8'h11;
   localparam logic [7:0] SPH_STOP_CODE = 8'h93;
   // line levels: logic 1 is the on (spacing) state, logic 0 off (marking)
   localparam logic SPH_SPACE = 1'b1;
   localparam logic SPH_MARK = 1'b0;
   // reset values of the data path
   localparam logic [7:0] SPH_ZERO_BYTE = 8'h00;
   localparam logic [2:0] SPH_ZERO_BIT = 3'h0;
   // transmitter and receiver sequencing
   typedef enum logic [1:0] {SPH_IDLE, SPH_START, SPH_DATA, SPH_STOP} sph_state_e;
endpackage

// ### design/sph_receiver.sv
// start-stop character receiver for the serial port handshake block
`timescale 1ns/10ps
module sph_receiver
   import sph_pkg::*;
(
   input wire logic core_clk, // 25 MHz core clock
   input wire logic resetn, // asynchronous reset, active low
   input wire logic rx_line, // receive data line, 1 = on (spacing)
   input wire logic abort, // drop any character in progress
   output logic [7:0] rx_data, // last good character, bit 1 in bit 0
   output logic rx_valid, // one-cycle pulse per good character
   output logic rx_busy // a character is being received
);
   // all receiver state in one record
   typedef struct packed {
      sph_state_e st; // receive sequencer
      logic [7:0] cnt; // cycles left in current bit
      logic [2:0] bitn; // data bit being gathered
      logic [7:0] shreg; // gathered data bits
      logic [7:0] data; // delivered character
      logic valid; // delivery pulse
   } sph_rx_s;

   sph_rx_s r; // registered state
   sph_rx_s next_r; // next state

   // sequencer: sample each bit in its middle, lsb first
   always_comb
   begin
      next_r = r;
      next_r.valid = 1'b0;
      if (r.cnt != SPH_ZERO_BYTE)
         next_r.cnt = r.cnt - 8'h01;
      unique case (r.st)
         SPH_IDLE:
         begin
            // a start bit is a move from marking to spacing
            if (rx_line == SPH_SPACE)
            begin
               next_r.st = SPH_START;
               // the cycle spent at zero counts too, so reload one short
               next_r.cnt = SPH_HALF_CYCLES - 8'h01;
            end
         end
         SPH_START:
         begin
            // recheck mid start bit so a glitch does not open a frame
            if (r.cnt == SPH_ZERO_BYTE)
            begin
               next_r.st = (rx_line == SPH_SPACE) ? SPH_DATA : SPH_IDLE;
               // a full reload would drift one cycle per bit past mid-bit
               next_r.cnt = SPH_BIT_CYCLES - 8'h01;
               next_r.bitn = SPH_ZERO_BIT;
            end
         end
         SPH_DATA:
         begin
            // marking carries a one, bits 1 to 8 in order
            if (r.cnt == SPH_ZERO_BYTE)
            begin
               next_r.shreg = {rx_line == SPH_MARK, r.shreg[7:1]};
               next_r.cnt = SPH_BIT_CYCLES - 8'h01;
               next_r.bitn = r.bitn + 3'h1;
               if (r.bitn == SPH_LAST_BIT)
                  next_r.st = SPH_STOP;
            end
         end
         SPH_STOP:
         begin
            // a spacing stop bit is a framing error; the character is dropped
            if (r.cnt == SPH_ZERO_BYTE)
            begin
               next_r.st = SPH_IDLE;
               if (rx_line == SPH_MARK)
               begin
                  next_r.data = r.shreg;
                  next_r.valid = 1'b1;
               end
            end
         end
      endcase
      // a lost data-set-ready ends the frame at once
      if (abort)
      begin
         next_r.st = SPH_IDLE;
         next_r.valid = 1'b0;
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         r <= '{SPH_IDLE, SPH_ZERO_BYTE, SPH_ZERO_BIT, SPH_ZERO_BYTE, SPH_ZERO_BYTE, 1'b0};
      else
         r <= next_r;
   end

   assign rx_data = r.data;
   assign rx_valid = r.valid;
   assign rx_busy = (r.st != SPH_IDLE);
endmodule

// ### design/sph_port.sv
// serial port with modem handshake: transmitter, flow control and alarm
`timescale 1ns/10ps
module sph_port
   import sph_pkg::*;
(
   input wire logic core_clk, // 25 MHz core clock
   input wire logic resetn, // asynchronous reset, active low
   input wire logic port_enable, // controller has the port ready
   input wire logic [7:0] tx_data, // character to send, bit 1 in bit 0
   input wire logic tx_valid, // tx_data offered
   output logic tx_ready, // one-character holding slot is free
   output logic [7:0] rx_data, // received character
   output logic rx_valid, // one-cycle pulse per received character
   input wire logic alarm_clear, // clears the alarm flag
   output logic alarm_086, // sticky: set-ready dropped during transfer
   output logic output_held, // output paused by stop code
   output logic transmit_line, // serial data out, 1 = on (spacing)
   input wire logic rx_line, // serial data in, 1 = on (spacing)
   output logic send_request, // send request out
   input wire logic send_permit, // send permitted in
   input wire logic peer_set_ready, // peer ready to operate
   output logic host_ready_out, // this port ready to operate
   input wire logic carrier_detect_in // not used; strapped to ready out in cable
);
   // all transmitter state in one record
   typedef struct packed {
      sph_state_e st; // transmit sequencer
      logic [7:0] cnt; // cycles left in current bit
      logic [2:0] bitn; // data bit on the line
      logic [7:0] shreg; // character being shifted out
      logic hold; // holding slot full
      logic [7:0] hold_data; // holding slot contents
      logic rdy; // copy of tx_ready
      logic line; // transmit line level
      logic req; // send request level
      logic er; // ready out level
      logic alarm; // alarm 086 flag
      logic xoff; // paused by stop code
   } sph_tx_s;

   sph_tx_s r; // registered state
   sph_tx_s next_r; // next state
   logic [7:0] rx_byte; // receiver character
   logic rx_pulse; // receiver delivery
   logic rx_busy; // receiver mid-frame
   logic xfer_lost; // set-ready dropped while a transfer runs

   // receiver shares the abort with the transmitter
   sph_receiver u_rx (
      .core_clk(core_clk),
      .resetn(resetn),
      .rx_line(rx_line),
      .abort(xfer_lost),
      .rx_data(rx_byte),
      .rx_valid(rx_pulse),
      .rx_busy(rx_busy)
   );

   // a transfer is a character on either wire or a pending request
   assign xfer_lost = !peer_set_ready && (r.st != SPH_IDLE || rx_busy || r.req);

   // transmitter, handshake and flow control
   always_comb
   begin
      next_r = r;
      next_r.er = port_enable;
      if (r.cnt != SPH_ZERO_BYTE)
         next_r.cnt = r.cnt - 8'h01;
      // holding slot takes a character when free
      if (tx_valid && r.rdy)
      begin
         next_r.hold = 1'b1;
         next_r.hold_data = tx_data;
      end
      // flow control codes from the peer; the later code wins
      if (rx_pulse && rx_byte == SPH_STOP_CODE)
         next_r.xoff = 1'b1;
      else if (rx_pulse && rx_byte == SPH_START_CODE)
         next_r.xoff = 1'b0;
      unique case (r.st)
         SPH_IDLE:
         begin
            // request goes up first so a looped-back permit can follow it
            next_r.req = r.hold;
            // a new character starts only with both lines on and no pause;
            // the one in flight finishes unless set-ready drops, so at most one goes out
            if (r.hold && r.req && send_permit && peer_set_ready && !r.xoff && r.er)
            begin
               next_r.st = SPH_START;
               next_r.shreg = r.hold_data;
               next_r.hold = 1'b0;
               next_r.cnt = SPH_BIT_CYCLES - 8'h01;
            end
         end
         SPH_START:
         begin
            if (r.cnt == SPH_ZERO_BYTE)
            begin
               next_r.st = SPH_DATA;
               next_r.bitn = SPH_ZERO_BIT;
               next_r.cnt = SPH_BIT_CYCLES - 8'h01;
            end
         end
         SPH_DATA:
         begin
            // bits 1 to 8, lsb first
            if (r.cnt == SPH_ZERO_BYTE)
            begin
               next_r.cnt = SPH_BIT_CYCLES - 8'h01;
               next_r.shreg = {1'b0, r.shreg[7:1]};
               next_r.bitn = r.bitn + 3'h1;
               if (r.bitn == SPH_LAST_BIT)
                  next_r.st = SPH_STOP;
            end
         end
         SPH_STOP:
         begin
            if (r.cnt == SPH_ZERO_BYTE)
               next_r.st = SPH_IDLE;
         end
      endcase
      // loss of set-ready aborts and flags; the pending character is dropped
      if (xfer_lost)
      begin
         next_r.st = SPH_IDLE;
         next_r.hold = 1'b0;
         next_r.req = 1'b0;
         next_r.alarm = 1'b1;
      end
      else if (alarm_clear)
         next_r.alarm = 1'b0; // set above wins over this clear
      // line level follows the next state so it lines up with the sequencer
      unique case (next_r.st)
         SPH_START: next_r.line = SPH_SPACE;
         SPH_DATA: next_r.line = next_r.shreg[0] ? SPH_MARK : SPH_SPACE;
         default: next_r.line = SPH_MARK; // stop bit and rest
      endcase
      next_r.rdy = !next_r.hold;
   end

   // state register
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         r <= '{SPH_IDLE, SPH_ZERO_BYTE, SPH_ZERO_BIT, SPH_ZERO_BYTE, 1'b0, SPH_ZERO_BYTE,
                1'b1, SPH_MARK, 1'b0, 1'b0, 1'b0, 1'b0};
      else
         r <= next_r;
   end

   // received data is re-timed so outputs come from flip-flops
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_data <= SPH_ZERO_BYTE;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_data <= rx_byte;
         rx_valid <= rx_pulse;
      end
   end

   assign tx_ready = r.rdy;
   assign alarm_086 = r.alarm;
   assign output_held = r.xoff;
   assign transmit_line = r.line;
   assign send_request = r.req;
   assign host_ready_out = r.er;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   logic char_start; // a character has just begun
   // the bit count stands full in the first cycle of every bit; within a start bit, only in its first cycle
   assign char_start = (r.st == SPH_START) && (r.cnt == SPH_BIT_CYCLES - 8'h01);

   a_req_covers_char: assert property (r.st != SPH_IDLE |-> send_request)
      else $error("send request low while a character is on the line");
   a_start_permitted: assert property (
      char_start |-> $past(send_permit) && $past(peer_set_ready))
      else $error("character started without permit and set-ready");
   a_permit_off_stop: assert property ($fell(send_permit) |-> ##[0:170] r.st == SPH_IDLE)
      else $error("output did not stop after permit went off");
   a_lost_ready_alarm: assert property (
      !peer_set_ready && r.st != SPH_IDLE |=> alarm_086 && r.st == SPH_IDLE)
      else $error("set-ready loss did not abort and raise alarm");
   a_ready_out_follows: assert property (port_enable ##1 port_enable |-> host_ready_out)
      else $error("ready out low while port enabled");
   a_frame_stop_bit: assert property (
      char_start ##144 !alarm_086 |-> r.st == SPH_STOP && transmit_line == SPH_MARK)
      else $error("stop bit not after start and eight data bits");
   a_start_is_space: assert property (char_start |-> transmit_line == SPH_SPACE [*8])
      else $error("start bit not spacing");
   a_pause_holds: assert property (r.xoff && r.st == SPH_IDLE |=> r.st == SPH_IDLE)
      else $error("character started while paused");
   a_rest_marking: assert property (r.st == SPH_IDLE |-> transmit_line == SPH_MARK)
      else $error("transmit line not marking at rest");

   c_char_sent: cover property (r.st == SPH_STOP ##1 r.st == SPH_IDLE);
   c_alarm_raised: cover property ($rose(alarm_086));
   c_pause_resume: cover property ($rose(output_held) ##[1:1000] $fell(output_held));
endmodule

// ### tb/sph_peer.sv
// behavioural model of the external serial device facing the port
`timescale 1ns/10ps
module sph_peer
   import sph_pkg::*;
(
   input wire logic core_clk, // port clock, paces the bit timing
   input wire logic transmit_line, // data from the port
   input wire logic send_request, // request from the port
   input wire logic host_ready_out, // port ready to operate
   output logic rx_line, // data towards the port
   output logic send_permit, // permit towards the port
   output logic peer_set_ready // this device ready
);
   logic use_permit; // low: permit strapped to the request line
   logic permit_en; // permit level while the line is used
   logic ready_en; // set-ready level, driven from our power-on state
   logic use_ready; // low: set-ready strapped to the port's ready out
   logic [7:0] b; // character being decoded
   logic [7:0] got[$]; // decoded characters, oldest first
   // strap the permit back to the request when we do not pace the port
   assign send_permit = use_permit ? permit_en : send_request;
   assign peer_set_ready = use_ready ? ready_en : host_ready_out;
   initial
   begin
      use_permit = 1'b0;
      use_ready = 1'b0;
      permit_en = 1'b1;
      ready_en = 1'b1;
      rx_line = SPH_MARK;
   end
   // decode frames; the line means nothing while the port is not ready
   initial
   forever
   begin
      @(posedge core_clk);
      if (host_ready_out === 1'b1 && transmit_line === SPH_SPACE)
      begin
         repeat (8) @(posedge core_clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (16) @(posedge core_clk);
            b[i] = ~transmit_line;
         end
         repeat (16) @(posedge core_clk);
         // a frame without a marking stop bit is dropped, so the bench sees it
         if (transmit_line === SPH_MARK)
            got.push_back(b);
      end
   end
   // send one framed character to the port, bit 1 first
   task automatic send_byte(input logic [7:0] c);
      logic [9:0] f;
      f = {SPH_MARK, ~c, SPH_SPACE};
      for (int k = 0; k < 10; k++)
      begin
         @(posedge core_clk);
         rx_line <= f[k];
         repeat (15) @(posedge core_clk);
      end
   endtask
endmodule

// ### tb/sph_port_tb.sv
// self-checking bench for the serial port handshake block
`timescale 1ns/10ps
module sph_port_tb;
   import sph_pkg::*;
   logic core_clk, resetn, port_enable, tx_valid, tx_ready, rx_valid;
   logic alarm_clear, alarm_086, output_held, transmit_line, rx_line;
   logic send_request, send_permit, peer_set_ready, host_ready_out;
   logic [7:0] tx_data, rx_data;
   logic [7:0] exp_tx[$]; // characters the peer should decode
   logic [7:0] exp_rx[$]; // characters the port should report
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int seed = 32'hbf5a7320;
   sph_port dut (.core_clk(core_clk), .resetn(resetn), .port_enable(port_enable),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .alarm_clear(alarm_clear), .alarm_086(alarm_086),
      .output_held(output_held), .transmit_line(transmit_line), .rx_line(rx_line),
      .send_request(send_request), .send_permit(send_permit),
      .peer_set_ready(peer_set_ready), .host_ready_out(host_ready_out),
      .carrier_detect_in(host_ready_out));
   sph_peer peer (.core_clk(core_clk), .transmit_line(transmit_line),
      .send_request(send_request), .host_ready_out(host_ready_out), .rx_line(rx_line),
      .send_permit(send_permit), .peer_set_ready(peer_set_ready));
   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("errors %0d, comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // offer one character and hold it until the port takes it
   task automatic put(input logic [7:0] c);
      int n;
      n = 0;
      @(posedge core_clk);
      tx_data <= c;
      tx_valid <= 1'b1;
      exp_tx.push_back(c);
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (tx_ready !== 1'b1 && n < 2000);
      tx_valid <= 1'b0;
   endtask
   // wait for a start bit, then look at the handshake around it
   task automatic wait_start;
      int n;
      n = 0;
      while (transmit_line !== SPH_SPACE && n < 3000)
      begin
         @(posedge core_clk);
         n++;
      end
      check(8'(transmit_line), 8'(SPH_SPACE));
      check(8'(send_request), 8'h01);
      check(8'(send_permit & peer_set_ready), 8'h01);
   endtask
   // wait for n decoded characters and compare them all
   task automatic drain(input int n);
      int k;
      k = 0;
      while (peer.got.size() < n && k < 3000)
      begin
         @(posedge core_clk);
         k++;
      end
      check(8'(peer.got.size()), 8'(n));
      while (peer.got.size() > 0)
         check(peer.got.pop_front(), exp_tx.size() > 0 ? exp_tx.pop_front() : 8'hxx);
   endtask
   // every received character must match the model queue
   always @(posedge core_clk)
      if (rx_valid === 1'b1)
         check(rx_data, exp_rx.size() > 0 ? exp_rx.pop_front() : 8'hxx);
   // hang guard, well above the expected few thousand cycles
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         finish_test();
      end
   end
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial
   begin
      resetn = 1'b0;
      port_enable = 1'b0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      alarm_clear = 1'b0;
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      port_enable <= 1'b1;
      check(8'(transmit_line), 8'(SPH_MARK));
      repeat (2) @(posedge core_clk);
      check(8'(host_ready_out), 8'h01);
      // back-to-back characters with permit and set-ready both strapped
      put(8'($random(seed)));
      wait_start();
      put(8'($random(seed)));
      put(8'($random(seed)));
      drain(3);
      // the last stop bit still runs when the peer has decoded it
      repeat (12) @(posedge core_clk);
      check(8'(send_request), 8'h00);
      // permit withdrawn mid-frame: only the frame in flight may finish
      peer.use_permit <= 1'b1;
      peer.use_ready <= 1'b1;
      put(8'($random(seed)));
      wait_start();
      peer.permit_en <= 1'b0;
      put(8'($random(seed)));
      repeat (400) @(posedge core_clk);
      check(8'(peer.got.size()), 8'h01);
      peer.permit_en <= 1'b1;
      drain(2);
      // port not ready: nothing goes out
      port_enable <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(8'(host_ready_out), 8'h00);
      put(8'($random(seed)));
      repeat (300) @(posedge core_clk);
      check(8'(peer.got.size()) | 8'(transmit_line), 8'h00);
      port_enable <= 1'b1;
      drain(1);
      // receive path, then the stop and start codes
      for (int i = 0; i < 3; i++)
      begin
         exp_rx.push_back(8'($random(seed)));
         peer.send_byte(exp_rx[$]);
      end
      exp_rx.push_back(SPH_STOP_CODE);
      peer.send_byte(SPH_STOP_CODE);
      repeat (4) @(posedge core_clk);
      check(8'(output_held), 8'h01);
      put(8'($random(seed)));
      repeat (300) @(posedge core_clk);
      check(8'(peer.got.size()), 8'h00);
      exp_rx.push_back(SPH_START_CODE);
      peer.send_byte(SPH_START_CODE);
      repeat (4) @(posedge core_clk);
      check(8'(output_held), 8'h00);
      drain(1);
      // set-ready lost mid-frame: abort and sticky alarm
      put(8'($random(seed)));
      wait_start();
      repeat (40) @(posedge core_clk);
      peer.ready_en <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({6'h00, alarm_086, transmit_line | send_request}, 8'h02);
      peer.ready_en <= 1'b1;
      repeat (200) @(posedge core_clk);
      check(8'(alarm_086), 8'h01);
      alarm_clear <= 1'b1;
      @(posedge core_clk);
      alarm_clear <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(8'(alarm_086), 8'h00);
      peer.got.delete();
      exp_tx.delete();
      check(8'(exp_rx.size()), 8'h00);
      finish_test();
   end
endmodule
